// ===== design/frbo_core.sv
// file-register byte and bit operation unit: decode, read, process, write
//
// Behaviour
// - add acc to register; carry, digit carry, zero
// - and: acc AND register, update Z only
// - dest bit 0 to acc, 1 to register
// - bit clear/set opcodes, flags untouched
// - seven-bit address, three-bit bit select
// - one word, four phases per cycle
`timescale 1ns/10ps
module frbo_core
  import frbo_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [13:0] instr_word, // instruction latched by fetch, same clock
  input wire logic [7:0] reg_rd_data, // register file read data, same clock
  output logic [3:0] phase_reg, // current phase, one-hot
  output logic [6:0] reg_addr_reg, // register address
  output logic reg_rd_en_reg, // read strobe in read phase
  output logic reg_wr_en_reg, // write strobe in the decode phase after the write phase
  output logic [7:0] reg_wr_data_reg, // write data
  output logic [7:0] acc_reg, // working accumulator
  output logic carry_flag_reg,
  output logic digit_carry_flag_reg,
  output logic zero_flag_reg,
  output logic instr_done_reg // pulse in the decode phase after the write phase
);
  frbo_phase_t phase; // phase sequencer
  frbo_phase_t phase_next;
  frbo_kind_t kind_reg; // decoded operation
  frbo_kind_t kind_next;
  logic dest_reg; // destination select
  logic [2:0] bitsel_reg; // bit position
  logic [7:0] opnd_reg; // register value read
  logic [7:0] res_reg; // computed result
  logic [8:0] sum; // full add with carry out
  logic [4:0] low_sum; // low nibble add for digit carry
  logic [7:0] bit_mask; // one-hot select of the addressed bit

  // phase rotates every clock, one instruction each four clocks
  always_comb begin
    unique case (phase)
      PH_DECODE: phase_next = PH_READ;
      PH_READ: phase_next = PH_PROC;
      PH_PROC: phase_next = PH_WRITE;
      PH_WRITE: phase_next = PH_DECODE;
      default: phase_next = PH_DECODE; // illegal code recovers
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= PH_DECODE;
    end else begin
      phase <= phase_next;
    end
  end

  // decode table; anything else is ignored as no operation here
  always_comb begin
    kind_next = K_NONE;
    if (instr_word[BYTE_OP_MSB:BYTE_OP_LSB] == OPC_ADD) begin
      kind_next = K_ADD;
    end else if (instr_word[BYTE_OP_MSB:BYTE_OP_LSB] == OPC_AND) begin
      kind_next = K_AND;
    end else if (instr_word[BIT_OP_MSB:BIT_OP_LSB] == OPC_BCLR) begin
      kind_next = K_BCLR;
    end else if (instr_word[BIT_OP_MSB:BIT_OP_LSB] == OPC_BSET) begin
      kind_next = K_BSET;
    end
  end

  // decode phase captures operation and fields
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      kind_reg <= K_NONE;
      dest_reg <= 1'b0;
      bitsel_reg <= 3'h0;
      reg_addr_reg <= ADDR_RESET;
    end else if (phase == PH_DECODE) begin
      kind_reg <= kind_next;
      dest_reg <= instr_word[DEST_BIT];
      bitsel_reg <= instr_word[BITSEL_MSB:BITSEL_LSB];
      reg_addr_reg <= instr_word[ADDR_MSB:0];
    end
  end

  // read strobe during read phase; data sampled at its end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rd_en_reg <= 1'b0;
      opnd_reg <= DATA_RESET;
    end else begin
      reg_rd_en_reg <= (phase_next == PH_READ) && (kind_next != K_NONE);
      if (phase == PH_READ) begin
        opnd_reg <= reg_rd_data;
      end
    end
  end

  assign sum = {1'b0, acc_reg} + {1'b0, opnd_reg};
  assign low_sum = {1'b0, acc_reg[3:0]} + {1'b0, opnd_reg[3:0]};
  assign bit_mask = 8'h01 << bitsel_reg;

  // process phase computes the result
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      res_reg <= DATA_RESET;
    end else if (phase == PH_PROC) begin
      unique case (kind_reg)
        K_ADD: res_reg <= sum[7:0];
        K_AND: res_reg <= acc_reg & opnd_reg;
        K_BCLR: res_reg <= opnd_reg & ~bit_mask;
        K_BSET: res_reg <= opnd_reg | bit_mask;
        default: res_reg <= opnd_reg;
      endcase
    end
  end

  // flags updated in process phase; bit ops leave them alone
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      carry_flag_reg <= 1'b0;
      digit_carry_flag_reg <= 1'b0;
      zero_flag_reg <= 1'b0;
    end else if (phase == PH_PROC) begin
      if (kind_reg == K_ADD) begin
        carry_flag_reg <= sum[8];
        digit_carry_flag_reg <= low_sum[4];
        zero_flag_reg <= (sum[7:0] == 8'h00);
      end else if (kind_reg == K_AND) begin
        zero_flag_reg <= ((acc_reg & opnd_reg) == 8'h00);
      end
    end
  end

  // write phase: result to acc or back to register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg <= ACC_RESET;
      reg_wr_en_reg <= 1'b0;
      reg_wr_data_reg <= DATA_RESET;
      instr_done_reg <= 1'b0;
    end else begin
      reg_wr_en_reg <= 1'b0;
      instr_done_reg <= 1'b0;
      if (phase == PH_WRITE) begin
        instr_done_reg <= 1'b1;
        if (kind_reg == K_ADD || kind_reg == K_AND) begin
          if (!dest_reg) begin
            acc_reg <= res_reg;
          end else begin
            reg_wr_en_reg <= 1'b1;
            reg_wr_data_reg <= res_reg;
          end
        end else if (kind_reg == K_BCLR || kind_reg == K_BSET) begin
          reg_wr_en_reg <= 1'b1;
          reg_wr_data_reg <= res_reg;
        end
      end
    end
  end

  assign phase_reg = phase;

  // assertions
  // the three phases that must follow every decode phase
  sequence s_after_decode;
    phase == PH_READ ##1 phase == PH_PROC ##1 phase == PH_WRITE;
  endsequence
  a_phase_rotates: assert property (@(posedge sys_clk) disable iff (!rst_b)
    phase == PH_DECODE |=> s_after_decode)
    else $error("phase order broken");
  a_done_spacing: assert property (@(posedge sys_clk) disable iff (!rst_b)
    instr_done_reg |=> !instr_done_reg [*3] ##1 instr_done_reg)
    else $error("done not every four clocks");
  a_add_result: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (phase == PH_PROC && kind_reg == K_ADD) |=>
      res_reg == $past(sum[7:0]) && carry_flag_reg == $past(sum[8]))
    else $error("add result or carry wrong");
  a_and_flags: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (phase == PH_PROC && kind_reg == K_AND) |=>
      $stable(carry_flag_reg) && $stable(digit_carry_flag_reg)
      && zero_flag_reg == (res_reg == 8'h00))
    else $error("and touched carry or bad zero");
  a_dest_acc: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (phase == PH_WRITE && (kind_reg == K_ADD || kind_reg == K_AND) && !dest_reg) |=>
      acc_reg == $past(res_reg) && !reg_wr_en_reg)
    else $error("acc destination wrong");
  a_dest_reg: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (phase == PH_WRITE && kind_reg != K_NONE && (dest_reg || kind_reg[3] || kind_reg[4]))
      |=> reg_wr_en_reg && $stable(acc_reg))
    else $error("register destination wrong");
  a_bit_noflags: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (phase == PH_PROC && (kind_reg == K_BCLR || kind_reg == K_BSET)) |=>
      $stable(zero_flag_reg) && $stable(carry_flag_reg))
    else $error("bit op changed flags");
  a_bit_rmw: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (phase == PH_PROC && kind_reg == K_BSET) |=>
      (res_reg & ~bit_mask) == (opnd_reg & ~bit_mask) && (res_reg & bit_mask) != 8'h00)
    else $error("bit set disturbed other bits");
  a_addr_range: assert property (@(posedge sys_clk) disable iff (!rst_b)
    phase == PH_DECODE |=> reg_addr_reg == $past(instr_word[6:0]))
    else $error("address not captured");
  // digit carry is the carry out of the low nibble, worked out apart from low_sum
  a_add_flags: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (phase == PH_PROC && kind_reg == K_ADD) |=>
      digit_carry_flag_reg == (({1'b0, $past(acc_reg[3:0])} + {1'b0, $past(opnd_reg[3:0])}) > 5'h0F)
      && zero_flag_reg == (res_reg == 8'h00))
    else $error("add digit carry or zero wrong");
  // a clear must zero the chosen bit and keep every other bit as read
  a_bit_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (phase == PH_PROC && kind_reg == K_BCLR) |=>
      (res_reg & ~bit_mask) == (opnd_reg & ~bit_mask) && (res_reg & bit_mask) == 8'h00)
    else $error("bit clear disturbed other bits");
  // the read strobe may only stand in the read phase of a decoded operation
  a_rd_strobe: assert property (@(posedge sys_clk) disable iff (!rst_b)
    reg_rd_en_reg |-> phase == PH_READ && kind_reg != K_NONE)
    else $error("read strobe outside read phase");
  // the write strobe only follows a write phase, never elsewhere in the cycle
  a_wr_strobe: assert property (@(posedge sys_clk) disable iff (!rst_b)
    reg_wr_en_reg |-> phase == PH_DECODE && $past(phase) == PH_WRITE)
    else $error("write strobe outside write slot");
endmodule

// ===== design/frbo_pkg.sv
// package: encodings, phase codes and reset values for the file-register op unit
package frbo_pkg;
  // opcode field positions within the 14-bit word
  localparam int OP_WIDTH = 14;
  localparam int BYTE_OP_MSB = 13;
  localparam int BYTE_OP_LSB = 8;
  localparam int BIT_OP_MSB = 13;
  localparam int BIT_OP_LSB = 10;
  localparam int DEST_BIT = 7;
  localparam int BITSEL_MSB = 9;
  localparam int BITSEL_LSB = 7;
  localparam int ADDR_MSB = 6;
  // opcode encodings
  localparam logic [5:0] OPC_ADD = 6'h07;
  localparam logic [5:0] OPC_AND = 6'h05;
  localparam logic [3:0] OPC_BCLR = 4'h4;
  localparam logic [3:0] OPC_BSET = 4'h5;
  // reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  // kind of decoded operation
  typedef enum logic [4:0] {
    K_NONE = 5'b00001,
    K_ADD = 5'b00010,
    K_AND = 5'b00100,
    K_BCLR = 5'b01000,
    K_BSET = 5'b10000
  } frbo_kind_t;
  // four phases of one instruction cycle, one-hot
  typedef enum logic [3:0] {
    PH_DECODE = 4'b0001,
    PH_READ = 4'b0010,
    PH_PROC = 4'b0100,
    PH_WRITE = 4'b1000
  } frbo_phase_t;
endpackage

// ===== verif/frbo_regfile_model.sv
// data memory model answering the op unit's read and write strobes
`timescale 1ns/10ps
module frbo_regfile_model (
  input wire logic sys_clk,
  input wire logic [6:0] reg_addr_reg,
  input wire logic reg_rd_en_reg,
  input wire logic reg_wr_en_reg,
  input wire logic [7:0] reg_wr_data_reg,
  output logic [7:0] reg_rd_data
);
  logic [7:0] mem [128]; // contents, preloaded by the bench
  logic [7:0] last_q = 8'hA5; // last value put on the bus
  // idle bus shows the inverse so stale data never passes for a read
  assign reg_rd_data = reg_rd_en_reg ? mem[reg_addr_reg] : ~last_q;
  // writes land on the strobe edge
  always @(posedge sys_clk) begin
    if (reg_wr_en_reg) begin
      mem[reg_addr_reg] <= reg_wr_data_reg;
    end
    if (reg_rd_en_reg) begin
      last_q <= mem[reg_addr_reg];
    end
  end
endmodule

// ===== verif/test_file_register_byte_bit_ops.sv
// self-checking bench for the file-register op unit
`timescale 1ns/10ps
module test_file_register_byte_bit_ops;
  import frbo_pkg::*;
  // expected outcome of one instruction
  typedef struct packed {
    logic rd; logic wr; logic [6:0] a; logic [7:0] wd; logic [7:0] acc; logic [2:0] f;
  } frbo_exp_t;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [13:0] instr_word = 14'h0000;
  logic [7:0] reg_rd_data, reg_wr_data_reg, acc_reg;
  logic [3:0] phase_reg;
  logic [6:0] reg_addr_reg;
  logic reg_rd_en_reg, reg_wr_en_reg, instr_done_reg;
  logic carry_flag_reg, digit_carry_flag_reg, zero_flag_reg;
  logic [7:0] shadow [128]; // expected memory
  frbo_exp_t st = '0; // acc and flags carried between instructions
  frbo_exp_t q[$]; // issued, not yet completed
  logic [13:0] corner [8] = '{14'h057F, 14'h107F, 14'h077F, 14'h147F,
                              14'h07FF, 14'h13FF, 14'h3FFF, 14'h1780};
  int mismatches = 0;
  int n_compared = 0;
  always #20 sys_clk = ~sys_clk;
  frbo_core DUT (.sys_clk(sys_clk), .rst_b(rst_b), .instr_word(instr_word),
    .reg_rd_data(reg_rd_data), .phase_reg(phase_reg), .reg_addr_reg(reg_addr_reg),
    .reg_rd_en_reg(reg_rd_en_reg), .reg_wr_en_reg(reg_wr_en_reg),
    .reg_wr_data_reg(reg_wr_data_reg), .acc_reg(acc_reg), .carry_flag_reg(carry_flag_reg),
    .digit_carry_flag_reg(digit_carry_flag_reg), .zero_flag_reg(zero_flag_reg),
    .instr_done_reg(instr_done_reg));
  frbo_regfile_model P (.sys_clk(sys_clk), .reg_addr_reg(reg_addr_reg),
    .reg_rd_en_reg(reg_rd_en_reg), .reg_wr_en_reg(reg_wr_en_reg),
    .reg_wr_data_reg(reg_wr_data_reg), .reg_rd_data(reg_rd_data));
  task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
    n_compared++;
    if (e !== s) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // what one instruction should do, from acc, flags and expected memory
  function automatic frbo_exp_t predict(logic [13:0] w);
    frbo_exp_t e;
    logic [8:0] s;
    logic [7:0] r;
    e = st;
    e.rd = 1'b1;
    e.a = w[6:0];
    r = shadow[w[6:0]];
    s = {1'b0, st.acc} + {1'b0, r};
    e.wd = w[10] ? r | (8'h01 << w[9:7]) : r & ~(8'h01 << w[9:7]);
    if (w[13:8] == 6'h07) begin
      e.wd = s[7:0];
      e.f = {s[8], (st.acc[3:0] + r[3:0]) > 5'h0F, s[7:0] == 8'h00};
    end else if (w[13:8] == 6'h05) begin
      e.wd = st.acc & r;
      e.f[0] = e.wd == 8'h00;
    end else if (w[13:11] != 3'h2) begin
      e.rd = 1'b0; // not one of ours: ignored
    end
    e.wr = e.rd & (w[13:11] == 3'h2 | w[7]);
    if (e.rd & !e.wr) e.acc = e.wd;
    return e;
  endfunction
  // one instruction per four clocks, back to back
  task automatic issue(logic [13:0] w);
    frbo_exp_t e;
    e = predict(w);
    instr_word <= w;
    q.push_back(e);
    st = e;
    if (e.wr) shadow[e.a] = e.wd;
    repeat (4) @(posedge sys_clk);
  endtask
  // watch the read phase and the completion pulse
  always @(negedge sys_clk) begin
    if (rst_b && phase_reg === 4'h2 && q.size() > 0) begin
      chk("read strobe", q[0].rd, reg_rd_en_reg);
      if (q[0].rd) chk("address", q[0].a, reg_addr_reg);
    end
    if (rst_b && instr_done_reg === 1'b1) begin
      if (q.size() == 0) begin
        chk("done", 8'h00, 8'h01);
      end else begin
        chk("phase", 8'h01, phase_reg);
        chk("write strobe", q[0].wr, reg_wr_en_reg);
        if (q[0].wr) chk("write data", q[0].wd, reg_wr_data_reg);
        chk("acc", q[0].acc, acc_reg);
        chk("flags", q[0].f, {carry_flag_reg, digit_carry_flag_reg, zero_flag_reg});
        void'(q.pop_front());
      end
    end
  end
  initial begin
    logic [13:0] w;
    void'($urandom(59216));
    for (int i = 0; i < 128; i++) begin
      shadow[i] = (i == 127) ? 8'hFF : 8'($urandom);
      P.mem[i] = shadow[i];
    end
    @(negedge sys_clk);
    chk("reset phase", 8'h01, phase_reg);
    chk("reset acc", 8'h00, acc_reg);
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (corner[i]) issue(corner[i]);
    for (int i = 0; i < 300; i++) begin
      w = 14'($urandom);
      case ($urandom % 5)
        0: w[13:8] = 6'h07;
        1: w[13:8] = 6'h05;
        2: w[13:10] = 4'h4;
        3: w[13:10] = 4'h5;
        default: w[13:12] = 2'h3;
      endcase
      issue(w);
    end
    // the last completion pulse is popped at the next falling edge; look after it
    repeat (2) @(negedge sys_clk);
    chk("pending", 8'h00, 8'(q.size()));
    end_of_test();
  end
  // hang guard
  initial begin
    repeat (3000) @(posedge sys_clk);
    mismatches++;
    end_of_test();
  end
endmodule
